// file: tb/target_uart_model.sv
// Behavioural target UART with request/clear-to-send pins.
// Assumes the bench sets div, hs_en and rts_ready and calls send_byte.
`timescale 1ns/100ps
`default_nettype none
module target_uart_model (
    // Clock
    input  wire logic i_clk,
    // Serial lines
    input  wire logic i_line_in,
    output logic      o_line_out,
    // Flow control pins
    input  wire logic i_cts_n,
    input  wire logic i_cts_oe_n,
    output logic      o_rts_n
);
    int         div       = 43;
    logic       hs_en     = 1'b0;
    logic       rts_ready = 1'b1;
    logic [7:0] rx_q[$];
    logic       cts_pin;

    // Undriven pin floats to its pull-up level, which reads as stop
    assign cts_pin = i_cts_oe_n ? 1'b1 : i_cts_n;
    // Low means room to receive
    assign o_rts_n = ~rts_ready;
    initial o_line_out = 1'b1;

    // Start bit, 8 data LSB first, stop, one idle bit
    task automatic send_byte(input logic [7:0] b);
        @(posedge i_clk);
        // Checked only before a start bit; a frame is never cut
        while (hs_en && cts_pin) @(posedge i_clk);
        for (int i = 0; i < 11; i++) begin
            #2;
            o_line_out = (i == 0) ? 1'b0 : (i < 9) ? b[i-1] : 1'b1;
            repeat (div) @(posedge i_clk);
        end
    endtask

    // Takes every frame, also the one after request-to-send drops
    initial begin : rx
        logic [7:0] b;
        forever begin
            @(negedge i_line_in);
            repeat (div / 2) @(posedge i_clk);
            for (int i = 0; i < 8; i++) begin
                repeat (div) @(posedge i_clk);
                b[i] = i_line_in;
            end
            repeat (div) @(posedge i_clk);
            rx_q.push_back(b);
        end
    end
endmodule // target_uart_model
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the serial bridge and its flow control.
// Assumes the target model file is compiled before this one.
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp, msg) \
    begin checked++; if ((got) !== (exp)) begin miscompares++; \
    $display("CHECK FAILED t=%0t %s", $time, msg); end end
module tb;
    logic                        i_clk       = 1'b0;
    logic                        i_rst_n     = 1'b0;
    logic                        i_link_en   = 1'b1;
    vcom_bridge_pkg::hs_mode_t   i_mode      = vcom_bridge_pkg::HS_DISABLED;
    logic [15:0]                 i_baud_div  = 16'h002B;
    logic                        i_h2t_valid = 1'b0;
    logic [7:0]                  i_h2t_data  = 8'h00;
    logic                        o_h2t_ready;
    vcom_bridge_pkg::byte_beat_t o_t2h;
    logic                        i_t2h_ready = 1'b0;
    logic                        o_txd;
    logic                        i_rxd;
    logic                        i_rts_n;
    logic                        o_cts_n;
    logic                        o_cts_oe_n;
    logic                        o_tx_busy;
    int                          miscompares = 0;
    int                          checked     = 0;
    int                          cycles      = 0;

    always #12.5 i_clk = ~i_clk;

    vcom_bridge dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_link_en(i_link_en),
        .i_mode(i_mode), .i_baud_div(i_baud_div), .i_h2t_valid(i_h2t_valid),
        .i_h2t_data(i_h2t_data), .o_h2t_ready(o_h2t_ready), .o_t2h(o_t2h),
        .i_t2h_ready(i_t2h_ready), .o_txd(o_txd), .i_rxd(i_rxd),
        .i_rts_n(i_rts_n), .o_cts_n(o_cts_n), .o_cts_oe_n(o_cts_oe_n),
        .o_tx_busy(o_tx_busy));

    target_uart_model tgt (.i_clk(i_clk), .i_line_in(o_txd),
        .o_line_out(i_rxd), .i_cts_n(o_cts_n), .i_cts_oe_n(o_cts_oe_n),
        .o_rts_n(i_rts_n));

    task automatic close_out();
        if (miscompares == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Ceiling well above the longest expected run
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            close_out();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #2;
    endtask

    // Valid held until the edge at which ready is seen high
    task automatic host_send(input logic [7:0] d);
        i_h2t_valid = 1'b1;
        i_h2t_data  = d;
        for (int i = 0; i < 3000; i++) begin
            @(negedge i_clk);
            if (o_h2t_ready === 1'b1) break;
        end
        step(1);
        i_h2t_valid = 1'b0;
    endtask

    task automatic expect_rx(input logic [7:0] e);
        step(2);
        for (int i = 0; i < 5000 && o_tx_busy !== 1'b0; i++) step(1);
        step(5);
        `CHK(tgt.rx_q.size(), 1, "target frame count")
        if (tgt.rx_q.size() > 0) `CHK(tgt.rx_q.pop_front(), e, "tx byte")
    endtask

    task automatic host_read(input logic [7:0] e, input int wait_n);
        step(1);
        i_t2h_ready = 1'b1;
        for (int i = 0; i < wait_n; i++) begin
            @(negedge i_clk);
            if (o_t2h.valid === 1'b1) break;
        end
        `CHK(o_t2h.valid, 1'b1, "host byte missing")
        `CHK(o_t2h.data, e, "host byte value")
        step(1);
        i_t2h_ready = 1'b0;
    endtask

    task automatic t_modes();
        tgt.rts_ready = 1'b0;
        for (int m = 0; m < 4; m++) begin
            i_mode = vcom_bridge_pkg::hs_mode_t'(m);
            step(4);
            @(negedge i_clk);
            `CHK(o_cts_oe_n, ~m[0], "cts drive")
            `CHK(o_cts_n, 1'b0, "cts room")
            `CHK(o_h2t_ready, ~m[1], "rts gating")
        end
        step(1);
    endtask

    task automatic t_ignore_rts();
        i_mode = vcom_bridge_pkg::HS_RTS;
        tgt.rts_ready = 1'b0;
        step(4);
        host_send(8'h3C);
        expect_rx(8'h3C);
    endtask

    task automatic t_midchar();
        logic moved;
        i_mode = vcom_bridge_pkg::HS_CTS;
        tgt.rts_ready = 1'b1;
        step(4);
        host_send(8'hA5);
        step(100);
        tgt.rts_ready = 1'b0;
        expect_rx(8'hA5);
        moved = 1'b0;
        i_h2t_valid = 1'b1;
        i_h2t_data  = 8'h5A;
        repeat (600) begin
            @(negedge i_clk);
            if (o_tx_busy !== 1'b0 || o_txd !== 1'b1) moved = 1'b1;
        end
        `CHK(moved, 1'b0, "send while rts off")
        step(1);
        tgt.rts_ready = 1'b1;
        host_send(8'h5A);
        expect_rx(8'h5A);
    endtask

    // Fills the receive FIFO and output register with the host stalled
    task automatic t_fill();
        i_mode = vcom_bridge_pkg::HS_RTSCTS;
        tgt.hs_en = 1'b1;
        step(4);
        fork
            for (int k = 0; k < 6; k++) tgt.send_byte(8'h10 + 8'(k));
        join_none
        step(2800);
        `CHK(o_cts_n, 1'b1, "cts at full")
        for (int k = 0; k < 6; k++) host_read(8'h10 + 8'(k), 1500);
        step(3);
        `CHK(o_cts_n, 1'b0, "cts after drain")
        tgt.hs_en = 1'b0;
    endtask

    task automatic t_link_off();
        logic seen;
        i_link_en = 1'b0;
        step(4);
        @(negedge i_clk);
        `CHK(o_h2t_ready, 1'b0, "ready with link off")
        `CHK(o_cts_n, 1'b1, "cts with link off")
        step(1);
        tgt.send_byte(8'h77);
        step(0);
        seen = 1'b0;
        i_t2h_ready = 1'b1;
        repeat (100) begin
            @(negedge i_clk);
            if (o_t2h.valid !== 1'b0) seen = 1'b1;
        end
        `CHK(seen, 1'b0, "byte passed with link off")
        step(1);
        i_t2h_ready = 1'b0;
        i_link_en   = 1'b1;
        step(4);
    endtask

    // Zero divider selects the default rate; start bit length measured
    task automatic t_default_rate();
        int n;
        i_baud_div = 16'h0000;
        tgt.div    = 347;
        host_send(8'h01);
        @(negedge i_clk);
        n = 0;
        while (o_txd === 1'b0 && n < 1000) begin
            n++;
            @(negedge i_clk);
        end
        `CHK(n, 347, "default bit period")
        expect_rx(8'h01);
        i_baud_div = 16'h002B;
        tgt.div    = 43;
    endtask

    initial begin
        step(2);
        `CHK(o_txd, 1'b1, "txd in reset")
        `CHK(o_cts_oe_n, 1'b1, "cts undriven in reset")
        `CHK(o_tx_busy, 1'b0, "busy in reset")
        step(3);
        i_rst_n = 1'b1;
        step(2);
        t_modes();
        t_ignore_rts();
        t_midchar();
        t_fill();
        t_link_off();
        t_default_rate();
        close_out();
    end
endmodule // tb
`default_nettype wire

// file: verilog/vcom_bridge.sv
// Bridge end of a UART link with RTS/CTS flow control toward a target.
// Assumes target pins are asynchronous; host side is same-clock logic.
`timescale 1ns/100ps
`default_nettype none
`include "vcom_bridge_params.svh"
module vcom_bridge #(
    parameter int CLK_HZ = `VB_CLK_HZ,
    parameter int DEPTH  = `VB_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_n,
    // Configuration
    input  wire logic                  i_link_en,
    input  wire vcom_bridge_pkg::hs_mode_t i_mode,
    input  wire logic [`VB_DIV_W-1:0]  i_baud_div,
    // Host to target stream
    input  wire logic                  i_h2t_valid,
    input  wire logic [7:0]            i_h2t_data,
    output logic                       o_h2t_ready,
    // Target to host stream
    output vcom_bridge_pkg::byte_beat_t o_t2h,
    input  wire logic                  i_t2h_ready,
    // Target pins
    output logic                       o_txd,
    input  wire logic                  i_rxd,
    input  wire logic                  i_rts_n,
    output logic                       o_cts_n,
    output logic                       o_cts_oe_n,
    // Status
    output logic                       o_tx_busy
);
    // Divider holds clocks per bit; 0 means the default rate
    localparam int DEF_DIV = CLK_HZ / `VB_BAUD_DEFAULT;
    localparam int MIN_DIV = CLK_HZ / `VB_BAUD_MAX;
    localparam int MAX_DIV = CLK_HZ / `VB_BAUD_MIN;

    if (MIN_DIV < 4 || MAX_DIV >= (1 << `VB_DIV_W)) begin : g_bad_rate
        $error("vcom_bridge clock rate cannot serve the baud range");
    end

    logic [`VB_DIV_W-1:0] div;
    always_comb begin
        div = i_baud_div; // RULE15
        if (i_baud_div == '0) begin
            div = `VB_DIV_W'(DEF_DIV); // RULE14
        end else if (i_baud_div < `VB_DIV_W'(MIN_DIV)) begin
            div = `VB_DIV_W'(MIN_DIV);
        end else if (i_baud_div > `VB_DIV_W'(MAX_DIV)) begin
            div = `VB_DIV_W'(MAX_DIV);
        end
    end

    // Two-stage synchronisers for the asynchronous target pins
    logic [1:0] rxd_s_q;
    logic [1:0] rts_s_q;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rxd_s_q <= 2'h3;
            rts_s_q <= 2'h3;
        end else begin
            rxd_s_q <= {rxd_s_q[0], i_rxd};
            rts_s_q <= {rts_s_q[0], i_rts_n};
        end
    end
    logic rxd;
    logic rts_ok;
    assign rxd    = rxd_s_q[1];
    assign rts_ok = !rts_s_q[1]; // RULE17

    logic gate_tx;
    logic drive_cts;
    assign gate_tx   = i_mode[1]; // RULE10 RULE11 RULE12
    assign drive_cts = i_mode[0]; // RULE8 RULE9

    // Transmitter toward the target
    vcom_bridge_pkg::line_state_t tx_st_q;
    logic [`VB_DIV_W-1:0] tx_cnt_q;
    logic [2:0]           tx_bit_q;
    logic [7:0]           tx_sh_q;
    logic                 txd_q;
    logic                 tx_go;
    logic                 tx_tick;

    assign tx_tick = (tx_cnt_q == div - 1'b1);
    // Start only when idle; a character in flight always completes
    logic                 h2t_ready_q;
    assign tx_go = (tx_st_q == vcom_bridge_pkg::LN_IDLE) && h2t_ready_q
                   && i_h2t_valid;
    assign o_h2t_ready = h2t_ready_q;

    // Ready is a flop, so link changes act one cycle late and rts pin changes three (after the synchroniser)
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            h2t_ready_q <= 1'b0;
        end else begin
            h2t_ready_q <= i_link_en && (!gate_tx || rts_ok) // RULE5 RULE16
                && (((tx_st_q == vcom_bridge_pkg::LN_IDLE) && !tx_go)
                    || ((tx_st_q == vcom_bridge_pkg::LN_STOP) && tx_tick));
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_st_q  <= vcom_bridge_pkg::LN_IDLE;
            tx_cnt_q <= '0;
            tx_bit_q <= '0;
            tx_sh_q  <= '0;
            txd_q    <= 1'b1;
        end else begin
            tx_cnt_q <= tx_tick ? '0 : tx_cnt_q + 1'b1;
            unique case (tx_st_q)
                vcom_bridge_pkg::LN_IDLE: begin
                    tx_cnt_q <= '0;
                    txd_q    <= 1'b1;
                    if (tx_go) begin
                        tx_sh_q <= i_h2t_data;
                        txd_q   <= 1'b0;
                        tx_st_q <= vcom_bridge_pkg::LN_START;
                    end
                end
                vcom_bridge_pkg::LN_START: begin
                    if (tx_tick) begin
                        txd_q    <= tx_sh_q[0];
                        tx_bit_q <= '0;
                        tx_st_q  <= vcom_bridge_pkg::LN_DATA;
                    end
                end
                vcom_bridge_pkg::LN_DATA: begin
                    // No abort path here even if the target withdraws
                    if (tx_tick) begin // RULE6
                        if (tx_bit_q == 3'h7) begin
                            txd_q   <= 1'b1;
                            tx_st_q <= vcom_bridge_pkg::LN_STOP;
                        end else begin
                            txd_q    <= tx_sh_q[tx_bit_q + 3'h1];
                            tx_bit_q <= tx_bit_q + 3'h1;
                        end
                    end
                end
                vcom_bridge_pkg::LN_STOP: begin
                    if (tx_tick) begin
                        tx_st_q <= vcom_bridge_pkg::LN_IDLE;
                    end
                end
            endcase
        end
    end
    assign o_txd = txd_q;

    logic tx_busy_q;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_busy_q <= 1'b0;
        end else begin
            tx_busy_q <= (tx_st_q != vcom_bridge_pkg::LN_IDLE) || tx_go;
        end
    end
    assign o_tx_busy = tx_busy_q;

    // Receiver from the target, mid-bit sampling
    vcom_bridge_pkg::line_state_t rx_st_q;
    logic [`VB_DIV_W-1:0] rx_cnt_q;
    logic [2:0]           rx_bit_q;
    logic [7:0]           rx_sh_q;
    vcom_bridge_pkg::byte_beat_t rx_beat_q;
    logic                 rx_tick;
    logic                 rx_half;

    assign rx_tick = (rx_cnt_q == div - 1'b1);
    assign rx_half = (rx_cnt_q == (div >> 1));

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_st_q   <= vcom_bridge_pkg::LN_IDLE;
            rx_cnt_q  <= '0;
            rx_bit_q  <= '0;
            rx_sh_q   <= '0;
            rx_beat_q <= '0;
        end else begin
            rx_beat_q.valid <= 1'b0;
            rx_cnt_q <= rx_tick ? '0 : rx_cnt_q + 1'b1;
            unique case (rx_st_q)
                vcom_bridge_pkg::LN_IDLE: begin
                    rx_cnt_q <= '0;
                    if (!rxd && i_link_en) begin // RULE16
                        rx_st_q <= vcom_bridge_pkg::LN_START;
                    end
                end
                vcom_bridge_pkg::LN_START: begin
                    // False start filtered at mid-bit
                    if (rx_half) begin
                        rx_cnt_q <= '0;
                        rx_bit_q <= '0;
                        rx_st_q  <= rxd ? vcom_bridge_pkg::LN_IDLE
                                        : vcom_bridge_pkg::LN_DATA;
                    end
                end
                vcom_bridge_pkg::LN_DATA: begin
                    if (rx_tick) begin
                        rx_sh_q  <= {rxd, rx_sh_q[7:1]};
                        rx_bit_q <= rx_bit_q + 3'h1;
                        if (rx_bit_q == 3'h7) begin
                            rx_st_q <= vcom_bridge_pkg::LN_STOP;
                        end
                    end
                end
                vcom_bridge_pkg::LN_STOP: begin
                    if (rx_tick) begin
                        // Bad stop bit drops the character
                        rx_beat_q.valid <= rxd && i_link_en;
                        rx_beat_q.data  <= rx_sh_q;
                        rx_st_q         <= vcom_bridge_pkg::LN_IDLE;
                    end
                end
            endcase
        end
    end

    // Receive buffer; overflow only if the target ignores clear-to-send
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic fifo_pop;

    vcom_fifo #(
        .WIDTH (`VB_DATA_BITS),
        .DEPTH (DEPTH)
    ) u_rx_fifo (
        .i_clk       (i_clk),
        .i_rst_n     (i_rst_n),
        .i_in_valid  (rx_beat_q.valid),
        .i_in_data   (rx_beat_q.data),
        .o_in_ready  (fifo_in_ready),
        .o_out_valid (fifo_out_valid),
        .o_out_data  (fifo_out_data),
        .i_out_ready (fifo_pop)
    );

    // Output register stage toward the host
    vcom_bridge_pkg::byte_beat_t t2h_q;
    assign fifo_pop = fifo_out_valid && (!t2h_q.valid || i_t2h_ready);
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            t2h_q <= '0;
        end else if (fifo_pop) begin
            t2h_q.valid <= 1'b1;
            t2h_q.data  <= fifo_out_data;
        end else if (i_t2h_ready) begin
            t2h_q.valid <= 1'b0;
        end
    end
    assign o_t2h = t2h_q;

    // Clear-to-send: low means room, enable low means driven
    logic cts_n_q;
    logic cts_oe_n_q;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cts_n_q    <= 1'b1;
            cts_oe_n_q <= 1'b1;
        end else begin
            cts_n_q    <= !fifo_in_ready || !i_link_en; // RULE2 RULE17
            cts_oe_n_q <= !drive_cts; // RULE1 RULE8 RULE9 RULE11
        end
    end
    assign o_cts_n    = cts_n_q;
    assign o_cts_oe_n = cts_oe_n_q;

    // Checks
    property p_full_withdraws;
        @(posedge i_clk) disable iff (!i_rst_n)
        !fifo_in_ready |=> o_cts_n;
    endproperty
    a_full_withdraws: assert property (p_full_withdraws) // RULE2
        else $error("cts not withdrawn with buffer full");

    property p_gate_start;
        @(posedge i_clk) disable iff (!i_rst_n)
        (gate_tx && !rts_ok) |=> !o_h2t_ready;
    endproperty
    a_gate_start: assert property (p_gate_start) // RULE5
        else $error("start taken while rts withdrawn");

    property p_no_abort;
        @(posedge i_clk) disable iff (!i_rst_n)
        $rose(tx_st_q == vcom_bridge_pkg::LN_START) |->
            (tx_st_q != vcom_bridge_pkg::LN_IDLE)[*8];
    endproperty
    a_no_abort: assert property (p_no_abort) // RULE6
        else $error("character cut short");

    property p_undriven;
        @(posedge i_clk) disable iff (!i_rst_n)
        !i_mode[0] |=> o_cts_oe_n;
    endproperty
    a_undriven: assert property (p_undriven) // RULE8
        else $error("cts driven in mode without it");

    property p_driven;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_mode[0] |=> !o_cts_oe_n;
    endproperty
    a_driven: assert property (p_driven) // RULE9
        else $error("cts not driven");

    property p_ignore_rts;
        @(posedge i_clk) disable iff (!i_rst_n)
        (!gate_tx && i_link_en && !o_h2t_ready
            && tx_st_q == vcom_bridge_pkg::LN_IDLE) |=> o_h2t_ready;
    endproperty
    a_ignore_rts: assert property (p_ignore_rts) // RULE12
        else $error("send held with flow control off");

    property p_link_off;
        @(posedge i_clk) disable iff (!i_rst_n)
        !i_link_en |=> !o_h2t_ready && o_cts_n;
    endproperty
    a_link_off: assert property (p_link_off) // RULE16
        else $error("data passed with link disabled");

    property p_busy;
        @(posedge i_clk) disable iff (!i_rst_n)
        (o_h2t_ready && i_h2t_valid) |=> o_tx_busy && !o_txd;
    endproperty
    a_busy: assert property (p_busy) // RULE1
        else $error("start bit missing after accept");

    c_send:  cover property (@(posedge i_clk) o_h2t_ready && i_h2t_valid);
    c_full:  cover property (@(posedge i_clk) !fifo_in_ready);
    c_held:  cover property (@(posedge i_clk) gate_tx && !rts_ok
                             && i_h2t_valid);
    c_recv:  cover property (@(posedge i_clk) o_t2h.valid);
endmodule // vcom_bridge
`default_nettype wire

// file: verilog/vcom_bridge_params.svh
// Constants for the serial bridge with hardware flow control.
// Assumes a 40 MHz core clock; included by the bridge design files.
// Overview of operation
// RULE1 - The bridge drives the target clear-to-send line as an output.
// RULE2 - The bridge withdraws clear-to-send while its receive buffer is full.
// RULE3 - The target transmitter stops while clear-to-send is withdrawn.
// RULE4 - The target drives request-to-send and asserts it only when ready.
// RULE5 - With flow control on, no new character starts while request-to-send is off.
// RULE6 - A character already in flight is finished, never aborted.
// RULE7 - The target accepts one more character after withdrawing request-to-send.
// RULE8 - Disabled mode leaves clear-to-send undriven and ignores request-to-send.
// RULE9 - Receive-only mode drives clear-to-send and ignores request-to-send.
// RULE10 - Transmit-only mode leaves clear-to-send undriven and gates sending.
// RULE11 - Full mode drives clear-to-send and gates sending on request-to-send.
// RULE12 - With flow control toward the target off, data is sent regardless.
// RULE13 - The target must drive request-to-send when that flow control is on.
// RULE14 - Default link setting is 115200 baud, 8N1, flow control disabled.
// RULE15 - Baud rate is settable from 9600 to 921600 and equal at both ends.
// RULE16 - Data passes only while the link enable is asserted; bytes already in the receive FIFO still drain to the host.
// RULE17 - Request-to-send and clear-to-send are active low.
`ifndef VCOM_BRIDGE_PARAMS_SVH
`define VCOM_BRIDGE_PARAMS_SVH

`define VB_CLK_HZ        40000000
`define VB_BAUD_DEFAULT  115200
`define VB_BAUD_MIN      9600
`define VB_BAUD_MAX      921600
`define VB_DATA_BITS     8
`define VB_FIFO_DEPTH    4
`define VB_DIV_W         16
`define VB_MODE_RESET    2'h0

`endif

// file: verilog/vcom_bridge_pkg.sv
// Types shared by the serial bridge files.
// Assumes nothing beyond the params header.
`default_nettype none
package vcom_bridge_pkg;
    typedef enum logic [1:0] {
        HS_DISABLED = 2'b00,
        HS_RTS      = 2'b01,
        HS_CTS      = 2'b10,
        HS_RTSCTS   = 2'b11
    } hs_mode_t;

    typedef enum logic [1:0] {
        LN_IDLE  = 2'b00,
        LN_START = 2'b01,
        LN_DATA  = 2'b10,
        LN_STOP  = 2'b11
    } line_state_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } byte_beat_t;
endpackage
`default_nettype wire

// file: verilog/vcom_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module vcom_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    // Fill side
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    // Drain side
    output logic                  o_out_valid,
    output logic [WIDTH-1:0]      o_out_data,
    input  wire logic             i_out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("vcom_fifo depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_q != '0);
    assign o_out_data  = mem_q[rd_q];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_q[wr_q] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // vcom_fifo
`default_nettype wire
